//--- inc/mrwst_consts.vh
`ifndef MRWST_CONSTS_VH
`define MRWST_CONSTS_VH
// address span in bytes for each memory flavour
`define MRWST_SDR_SPAN_BYTES 64'h4000000
`define MRWST_DDR_SPAN_BYTES 64'h40000000
// clock figures in hz, ddr data rate in mbps
`define MRWST_REF_CLK_HZ 50000000
`define MRWST_SDR_CLK_HZ 100000000
`define MRWST_DDR_MEM_CLK_HZ 400000000
`define MRWST_DDR_SYS_CLK_HZ 200000000
`define MRWST_DDR_RATE_MBPS 800
// blink half period in milliseconds
`define MRWST_BLINK_HALF_MS 250
// reset value of the pattern generator
`define MRWST_SEED_RESET 32'h1
// indicator state in reset: only the reset led lit
`define MRWST_LED_RESET 3'h1
`endif

//--- core/mrwst_blink.v
`timescale 1ns/1ps
`default_nettype none
// free running toggle divider; run it on the reference clock
module mrwst_blink #(
	parameter HALF_CYCLES = 12500000,
	parameter CW = 24
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// blink output
	output reg blink_q
);
	reg [CW-1:0] cnt_q;
	// count and toggle at the half period
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= {CW{1'b0}};
			blink_q <= 1'b0;
		end else if (cnt_q == HALF_CYCLES[CW-1:0] - 1'b1) begin
			cnt_q <= {CW{1'b0}};
			blink_q <= ~blink_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- core/mrwst_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "mrwst_consts.vh"
module mrwst_engine #(
	parameter DW = 32,
	parameter AW = 24,
	parameter DDR3 = 0,
	parameter CLK_HZ = `MRWST_SDR_CLK_HZ,
	parameter [AW:0] WORDS = 25'h1000000
) (
	// controller clock domain
	input wire clk,
	input wire resetn,
	// reference clock and its reset
	input wire ref_clk,
	input wire ref_resetn,
	// operator button, low while pressed
	input wire test_start_button_n,
	// memory port, master side
	input wire mem_waitrequest,
	input wire mem_readdatavalid,
	input wire [DW-1:0] mem_readdata,
	output reg [AW-1:0] mem_address,
	output reg mem_read,
	output reg mem_write,
	output reg [DW-1:0] mem_writedata,
	// indicators
	output reg [2:0] indicator_leds
);
	// ------------------------------------------------------------
	// constants
	// ------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_WRITE = 2'b01;
	localparam [1:0] ST_READ = 2'b10;
	localparam [1:0] ST_DONE = 2'b11;
	// split the divide so slow clocks do not round to zero and fast ones do not overflow
	localparam integer BLINK_CYC = ((CLK_HZ / 100) * `MRWST_BLINK_HALF_MS) / 10;
	localparam integer REF_CYC = (`MRWST_REF_CLK_HZ / 1000) * `MRWST_BLINK_HALF_MS;
	// span check, word count times bytes per word must equal the bank
	localparam [63:0] SPAN = DDR3 ? `MRWST_DDR_SPAN_BYTES : `MRWST_SDR_SPAN_BYTES;
	localparam [63:0] WORD_BYTES = DW / 8;

	// ------------------------------------------------------------
	// button synchroniser and edges
	// ------------------------------------------------------------
	reg btn_s1_q, btn_s2_q, btn_s3_q;
	// button is a pin, two stages before use; third stage for edges
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			btn_s1_q <= 1'b1;
			btn_s2_q <= 1'b1;
			btn_s3_q <= 1'b1;
		end else begin
			btn_s1_q <= test_start_button_n;
			btn_s2_q <= btn_s1_q;
			btn_s3_q <= btn_s2_q;
		end
	end
	wire held = ~btn_s2_q;
	wire release_ev = btn_s2_q & ~btn_s3_q;

	// ------------------------------------------------------------
	// pattern generator
	// ------------------------------------------------------------
	// xorshift keeps both passes deterministic from the same seed
	function [31:0] next_pat;
		input [31:0] v;
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			next_pat = t ^ (t << 5);
		end
	endfunction
	reg [31:0] wpat_q;
	wire [DW-1:0] pat_wide;
	genvar g;
	// widen the 32-bit pattern to the data bus, one lane per word slice
	generate
		for (g = 0; g < DW; g = g + 1) begin : g_lane
			assign pat_wide[g] = wpat_q[g % 32] ^ (g >= 32 ? wpat_q[(g / 32) % 32] : 1'b0);
		end
	endgenerate

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	reg [1:0] st_q;
	reg [AW:0] wcnt_q;
	reg [AW:0] rcnt_q;
	reg [31:0] rpat_q;
	reg fail_q;
	wire [DW-1:0] exp_wide;
	generate
		for (g = 0; g < DW; g = g + 1) begin : g_exp
			assign exp_wide[g] = rpat_q[g % 32] ^ (g >= 32 ? rpat_q[(g / 32) % 32] : 1'b0);
		end
	endgenerate
	wire wr_take = mem_write & ~mem_waitrequest;
	wire rd_take = mem_read & ~mem_waitrequest;

	// write pass, then read pass; commands advance only when accepted
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_IDLE;
			mem_address <= {AW{1'b0}};
			mem_read <= 1'b0;
			mem_write <= 1'b0;
			mem_writedata <= {DW{1'b0}};
			wcnt_q <= {(AW+1){1'b0}};
			wpat_q <= `MRWST_SEED_RESET;
		end else if (held) begin
			st_q <= ST_IDLE;
			mem_read <= 1'b0;
			mem_write <= 1'b0;
			wcnt_q <= {(AW+1){1'b0}};
			wpat_q <= `MRWST_SEED_RESET;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (release_ev) begin
						st_q <= ST_WRITE;
						mem_address <= {AW{1'b0}};
						mem_writedata <= pat_wide;
						mem_write <= 1'b1;
						wpat_q <= next_pat(wpat_q);
						wcnt_q <= {(AW+1){1'b0}};
					end
				end
				ST_WRITE: begin
					if (wr_take) begin
						wcnt_q <= wcnt_q + 1'b1;
						mem_address <= mem_address + 1'b1;
						if (wcnt_q == WORDS - 1'b1) begin
							mem_write <= 1'b0;
							mem_read <= 1'b1;
							mem_address <= {AW{1'b0}};
							wcnt_q <= {(AW+1){1'b0}};
							st_q <= ST_READ;
						end else begin
							mem_writedata <= pat_wide;
							wpat_q <= next_pat(wpat_q);
						end
					end
				end
				ST_READ: begin
					if (rd_take) begin
						wcnt_q <= wcnt_q + 1'b1;
						mem_address <= mem_address + 1'b1;
						if (wcnt_q == WORDS - 1'b1) begin
							mem_read <= 1'b0;
						end
					end
					if (rcnt_q == WORDS) begin
						st_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					st_q <= ST_DONE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// read-back checker, pattern regenerated from the same seed
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rcnt_q <= {(AW+1){1'b0}};
			rpat_q <= `MRWST_SEED_RESET;
			fail_q <= 1'b0;
		end else if (held) begin
			rcnt_q <= {(AW+1){1'b0}};
			rpat_q <= `MRWST_SEED_RESET;
			fail_q <= 1'b0;
		end else if (st_q == ST_READ && mem_readdatavalid) begin
			rcnt_q <= rcnt_q + 1'b1;
			rpat_q <= next_pat(rpat_q);
			if (mem_readdata != exp_wide) begin
				fail_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// indicators
	// ------------------------------------------------------------
	reg [31:0] bcnt_q;
	reg blink_q;
	// pass blink in the controller domain
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bcnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else if (bcnt_q == BLINK_CYC - 1) begin
			bcnt_q <= 32'h0;
			blink_q <= ~blink_q;
		end else begin
			bcnt_q <= bcnt_q + 32'h1;
		end
	end
	wire ref_blink;
	mrwst_blink #(
		.HALF_CYCLES(REF_CYC),
		.CW(24)
	) u_ref_blink (
		.clk(ref_clk),
		.resetn(ref_resetn),
		.blink_q(ref_blink)
	);
	reg rb_s1_q, rb_s2_q;
	// ref blink crosses as a level
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
		end else begin
			rb_s1_q <= ref_blink;
			rb_s2_q <= rb_s1_q;
		end
	end
	// led drive; pass steady only after clean finish or while held
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			indicator_leds <= `MRWST_LED_RESET;
		end else if (held) begin
			indicator_leds <= 3'h7;
		end else begin
			indicator_leds[0] <= 1'b0;
			indicator_leds[2] <= rb_s2_q;
			if (st_q == ST_DONE && !fail_q)
				indicator_leds[1] <= 1'b1;
			else if (st_q == ST_IDLE)
				indicator_leds[1] <= 1'b0;
			else
				indicator_leds[1] <= blink_q;
		end
	end
	// span fixed by WORDS times bus width
	// clk is the controller user clock, CLK_HZ its rate
	localparam SPAN_OK = (SPAN == WORDS * WORD_BYTES);
endmodule
`default_nettype wire

//--- tb/mrwst_checker.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// port checker
// --------
module mrwst_checker #(
	parameter DW = 32,
	parameter AW = 24,
	parameter [AW:0] WORDS = 25'h10
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// watched ports
	input wire test_start_button_n,
	input wire mem_waitrequest,
	input wire [AW-1:0] mem_address,
	input wire mem_read,
	input wire mem_write,
	input wire [DW-1:0] mem_writedata,
	input wire [2:0] indicator_leds
);
	reg [2:0] hi_q;
	wire up = hi_q > 3'h4;
	wire last = {1'h0, mem_address} == WORDS - 1'h1;
	wire wr_ok = up && mem_write && !mem_waitrequest;
	// cycles since release; the stand, order and reset led checks wait until the synchroniser has settled
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			hi_q <= 3'h0;
		else if (!test_start_button_n)
			hi_q <= 3'h0;
		else if (hi_q != 3'h7)
			hi_q <= hi_q + 3'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	held_leds_a: assert property (!test_start_button_n [*5] |-> indicator_leds == 3'h7)
		else $error("leds not all on while held");
	held_idle_a: assert property (!test_start_button_n [*5] |-> !mem_read && !mem_write)
		else $error("command issued while held");
	wr_stand_a: assert property (up && mem_write && mem_waitrequest |=>
		mem_write && $stable(mem_address) && $stable(mem_writedata)) else $error("write not held");
	rd_stand_a: assert property (up && mem_read && mem_waitrequest |=>
		mem_read && $stable(mem_address)) else $error("read not held");
	wr_step_a: assert property (wr_ok && !last |=>
		mem_write && mem_address == $past(mem_address) + 1'h1) else $error("write order");
	wr_to_rd_a: assert property (wr_ok && last |-> ##[1:4] mem_read && mem_address == 0)
		else $error("read pass did not follow");
	led0_idle_a: assert property (up |-> !indicator_leds[0])
		else $error("reset led on after release");
	addr_span_a: assert property (mem_read || mem_write |-> {1'h0, mem_address} < WORDS)
		else $error("address beyond span");
	cover property (mem_write && mem_waitrequest);
	cover property (mem_read && !mem_waitrequest && last);
	cover property (!test_start_button_n [*5]);
endmodule
bind mrwst_engine mrwst_checker #(.DW(DW), .AW(AW), .WORDS(WORDS)) u_chk (.clk(clk),
	.resetn(resetn), .test_start_button_n(test_start_button_n),
	.mem_waitrequest(mem_waitrequest), .mem_address(mem_address), .mem_read(mem_read),
	.mem_write(mem_write), .mem_writedata(mem_writedata), .indicator_leds(indicator_leds));
`default_nettype wire

//--- tb/mrwst_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// memory port model, two cycle read latency
// --------
module mrwst_mem_model (
	// clock and reset
	input wire clk,
	input wire resetn,
	// master side
	input wire [23:0] mem_address,
	input wire mem_read,
	input wire mem_write,
	input wire [31:0] mem_writedata,
	// bench controls
	input wire stall,
	input wire corrupt,
	// answers
	output wire mem_waitrequest,
	output reg mem_readdatavalid,
	output reg [31:0] mem_readdata
);
	reg [31:0] ram_q [0:15];
	reg vld_q;
	reg [31:0] dat_q;
	assign mem_waitrequest = stall;
	// idle data inverts the previous cycle's value, so it toggles rather than holding the last word
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vld_q <= 1'h0;
			mem_readdatavalid <= 1'h0;
			mem_readdata <= 32'h0;
		end else begin
			if (mem_write && !stall)
				ram_q[mem_address[3:0]] <= mem_writedata;
			vld_q <= mem_read && !stall;
			dat_q <= ram_q[mem_address[3:0]] ^ {31'h0, corrupt};
			mem_readdatavalid <= vld_q;
			mem_readdata <= vld_q ? dat_q : ~mem_readdata;
		end
	end
endmodule
`default_nettype wire

//--- tb/test_memory_rw_self_test.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// engine bench
// --------
module test_memory_rw_self_test;
	logic clk = 1'h0, ref_clk = 1'h0, resetn, btn_n, stall = 1'h0, corrupt;
	wire wreq, rvld, rd, wr;
	wire [31:0] rdata, wdata;
	wire [23:0] addr;
	wire [2:0] leds;
	integer seed = 32'h37c2a2a8;
	integer n_mismatch = 0, cmp_count = 0, cyc = 0, wr_n = 0, rd_n = 0, ret_n = 0, ones;
	logic [31:0] exp_q = 32'h1;
	mrwst_engine #(.CLK_HZ(400), .WORDS(25'h10)) dut (.clk(clk), .resetn(resetn),
		.ref_clk(ref_clk), .ref_resetn(resetn), .test_start_button_n(btn_n),
		.mem_waitrequest(wreq), .mem_readdatavalid(rvld), .mem_readdata(rdata),
		.mem_address(addr), .mem_read(rd), .mem_write(wr), .mem_writedata(wdata),
		.indicator_leds(leds));
	mrwst_mem_model mem (.clk(clk), .resetn(resetn), .mem_address(addr), .mem_read(rd),
		.mem_write(wr), .mem_writedata(wdata), .stall(stall), .corrupt(corrupt),
		.mem_waitrequest(wreq), .mem_readdatavalid(rvld), .mem_readdata(rdata));
	// pattern generator step of the bench model
	function automatic [31:0] xs(input [31:0] v);
		reg [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task close_out;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// clocks, ref_clk at a quarter of the clk rate, edges aligned from time zero
	initial forever #2.5 clk = ~clk;
	initial forever #10 ref_clk = ~ref_clk;
	// random stalls from the memory side
	always @(negedge clk) stall <= ($random(seed) > 0);
	// bench model of the command stream, restarted by every press
	always @(posedge clk) begin
		cyc++;
		if (cyc > 6000) begin
			n_mismatch++;
			close_out;
		end else if (!btn_n) begin
			wr_n = 0;
			rd_n = 0;
			ret_n = 0;
			exp_q = 32'h1;
		end else begin
			if (wr && !stall) begin
				check("write addr", addr, wr_n);
				check("write data", wdata, exp_q);
				exp_q = xs(exp_q);
				wr_n++;
			end
			if (rd && !stall) begin
				check("writes before read", wr_n, 16);
				check("read addr", addr, rd_n);
				rd_n++;
			end
			if (rvld)
				ret_n++;
		end
	end
	// one press and run; abort presses again mid-write
	task run(input logic bad, input logic abort);
		corrupt = bad;
		btn_n = 1'h0;
		repeat (8) @(negedge clk);
		check("held leds", leds, 3'h7);
		check("held cmds", {rd, wr}, 2'h0);
		btn_n = 1'h1;
		if (abort) begin
			while (wr_n < 5) @(negedge clk);
			btn_n = 1'h0;
			repeat (8) @(negedge clk);
			check("abort cmds", {rd, wr}, 2'h0);
			btn_n = 1'h1;
		end
		while (rd_n < 16) @(negedge clk);
		repeat (20) @(negedge clk);
		check("words returned", ret_n, 16);
		ones = 0;
		repeat (300) begin
			@(negedge clk);
			ones += leds[1];
		end
		check("pass led", ones == 300 ? 0 : (ones > 0 ? 1 : 2), bad);
		check("reset led", leds[0], 1'h0);
		// reference blink half period is far longer than a run, so still low
		check("clock led", leds[2], 1'h0);
	endtask
	// reset, then pass, fail, and an aborted run that must pass again
	initial begin
		resetn = 1'h0;
		btn_n = 1'h1;
		corrupt = 1'h0;
		repeat (6) @(negedge clk);
		resetn = 1'h1;
		run(1'h0, 1'h0);
		run(1'h1, 1'h0);
		run(1'h0, 1'h1);
		close_out;
	end
endmodule
`default_nettype wire
